// >>> pkg/dpw_pkg.sv
// Notes on behaviour
// - Byte captured on rising write strobe while chip select is held low.
// - Host waits two core cycles (16 ns) after the write strobe rises before load low.
// - Host writes both data bytes, then pulses load low when req_auto_load is set.
package dpw_pkg;

  // ----------------------------------------------------------------------
  // Device map
  // ----------------------------------------------------------------------
  localparam logic [1:0] DPW_ADDR_LOWER = 2'h0;
  localparam logic [1:0] DPW_ADDR_UPPER = 2'h1;
  localparam logic [1:0] DPW_ADDR_CTRL = 2'h3;
  localparam logic [7:0] DPW_CTRL_DEFAULT = 8'h11;
  localparam logic [3:0] DPW_UPPER_PAD = 4'h0;
  localparam int DPW_CODE_W = 12;
  localparam int DPW_UPPER_BITS = 4;

  // ----------------------------------------------------------------------
  // Pin timing, 125 MHz core clock
  // ----------------------------------------------------------------------
  localparam int DPW_CLK_PS = 8000;
  localparam int DPW_STROBE_NS = 16;
  localparam int DPW_LOAD_DELAY_NS = 5;
  localparam int DPW_STROBE_CYC = (DPW_STROBE_NS * 1000 + DPW_CLK_PS - 1) / DPW_CLK_PS;
  localparam int DPW_LOAD_DELAY_CYC_RAW =
    (DPW_LOAD_DELAY_NS * 1000 + DPW_CLK_PS - 1) / DPW_CLK_PS;
  localparam int DPW_LOAD_DELAY_CYC = (DPW_LOAD_DELAY_CYC_RAW < 1) ? 1 : DPW_LOAD_DELAY_CYC_RAW;
  localparam int DPW_CNT_W = 4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    DPW_IDLE = 7'h01,
    DPW_SETUP = 7'h02,
    DPW_STROBE = 7'h04,
    DPW_HOLD = 7'h08,
    DPW_NEXT = 7'h10,
    DPW_WAIT_LD = 7'h20,
    DPW_LOAD = 7'h40
  } dpw_state_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] data;
  } dpw_write_t;

  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic load_n;
    logic [1:0] addr;
    logic [7:0] data;
  } dpw_pins_t;

endpackage

// >>> rtl/dpw_seq_mem.sv
`timescale 1ns/1ps
// Three-entry write queue for one update: lower, upper, control.
module dpw_seq_mem
  import dpw_pkg::*;
(
  input wire logic core_clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire dpw_write_t wr_data,
  input wire logic [1:0] rd_idx,
  output dpw_write_t rd_data_ff
);

  dpw_write_t mem [0:2];

  always_ff @(posedge core_clk)
  begin
    if (ce)
    begin
      if (wr_en)
      begin
        mem[wr_idx] <= wr_data;
      end
      rd_data_ff <= mem[rd_idx];
    end
  end

endmodule // dpw_seq_mem

// >>> rtl/dpw_host.sv
`timescale 1ns/1ps
// Host-side controller that drives the parallel DAC write port.
module dpw_host
  import dpw_pkg::*;
#(
  parameter int CODE_W = DPW_CODE_W,
  parameter int STROBE_CYC = DPW_STROBE_CYC,
  parameter int LOAD_DELAY_CYC = DPW_LOAD_DELAY_CYC
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic [CODE_W-1:0] req_code,
  input wire logic req_ctrl_en,
  input wire logic [7:0] req_ctrl,
  input wire logic req_auto_load,
  input wire logic fast_settle,
  input wire logic power_down,
  output logic req_ready_ff,
  output logic done_ff,
  output dpw_pins_t pins_ff,
  output logic settling_speed_select_ff,
  output logic power_down_pin_ff
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [DPW_CNT_W-1:0] cyc(input int n);
    return DPW_CNT_W'(n - 1);
  endfunction

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  dpw_state_t state_ff, nxt_state;
  logic [DPW_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [1:0] idx_ff, nxt_idx;
  logic [1:0] last_ff, nxt_last;
  logic auto_ff, nxt_auto;
  logic nxt_ready, nxt_done;
  dpw_pins_t nxt_pins;
  logic nxt_spd, nxt_pwr;
  logic wr_en;
  logic [1:0] wr_idx;
  dpw_write_t wr_data;
  dpw_write_t rd_data_ff;
  logic [1:0] rd_idx;

  // Lower byte first, then upper, then control, so the code is complete
  // before the load pulse.
  always_comb
  begin
    wr_en = 1'b0;
    wr_idx = 2'h0;
    wr_data = '0;
    if (state_ff == DPW_IDLE && req_valid)
    begin
      wr_en = 1'b1;
      wr_idx = idx_ff;
      case (idx_ff)
        2'h0: wr_data = '{addr: DPW_ADDR_LOWER, data: req_code[7:0]};
        2'h1: wr_data = '{addr: DPW_ADDR_UPPER,
                          data: {DPW_UPPER_PAD, req_code[CODE_W-1:8]}};
        default: wr_data = '{addr: DPW_ADDR_CTRL, data: req_ctrl};
      endcase
    end
  end

  assign rd_idx = (state_ff == DPW_IDLE) ? 2'h0 : nxt_idx;

  dpw_seq_mem u_mem (
    .core_clk(core_clk),
    .ce(ce),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .rd_idx(rd_idx),
    .rd_data_ff(rd_data_ff)
  );

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_idx = idx_ff;
    nxt_last = last_ff;
    nxt_auto = auto_ff;
    nxt_pins = pins_ff;
    nxt_done = 1'b0;
    nxt_spd = fast_settle;
    nxt_pwr = power_down;
    case (state_ff)
      DPW_IDLE:
      begin
        if (req_valid)
        begin
          // The request is loaded over two cycles, three with control; ready stays high until the last.
          nxt_idx = idx_ff + 2'h1;
          if (idx_ff == 2'h2 || (idx_ff == 2'h1 && !req_ctrl_en))
          begin
            nxt_last = idx_ff;
            nxt_auto = req_auto_load;
            nxt_idx = 2'h0;
            nxt_state = DPW_SETUP;
          end
        end
      end
      DPW_SETUP:
      begin
        nxt_pins.addr = rd_data_ff.addr;
        nxt_pins.data = rd_data_ff.data;
        nxt_pins.cs_n = 1'b0;
        nxt_cnt = cyc(STROBE_CYC);
        nxt_state = DPW_STROBE;
      end
      DPW_STROBE:
      begin
        nxt_pins.we_n = 1'b0;
        if (cnt_ff == '0)
        begin
          nxt_cnt = cyc(STROBE_CYC);
          nxt_state = DPW_HOLD;
        end
        else
        begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      DPW_HOLD:
      begin
        // Rising strobe while chip select is still low captures the byte.
        nxt_pins.we_n = 1'b1;
        nxt_state = DPW_NEXT;
      end
      DPW_NEXT:
      begin
        nxt_pins.cs_n = 1'b1;
        if (idx_ff == last_ff)
        begin
          nxt_idx = 2'h0;
          nxt_cnt = cyc(LOAD_DELAY_CYC);
          nxt_state = auto_ff ? DPW_WAIT_LD : DPW_IDLE;
          nxt_done = !auto_ff;
        end
        else
        begin
          nxt_idx = idx_ff + 2'h1;
          nxt_state = DPW_SETUP;
        end
      end
      DPW_WAIT_LD:
      begin
        // Load must not fall until the strobe edge has settled.
        if (cnt_ff == '0)
        begin
          nxt_pins.load_n = 1'b0;
          nxt_cnt = cyc(STROBE_CYC);
          nxt_state = DPW_LOAD;
        end
        else
        begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      DPW_LOAD:
      begin
        if (cnt_ff == '0)
        begin
          // Load returns high so later writes leave the output alone.
          nxt_pins.load_n = 1'b1;
          nxt_done = 1'b1;
          nxt_state = DPW_IDLE;
        end
        else
        begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default:
      begin
        nxt_state = DPW_IDLE;
      end
    endcase
    nxt_ready = (nxt_state == DPW_IDLE);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_ff <= DPW_IDLE;
      cnt_ff <= '0;
      idx_ff <= 2'h0;
      last_ff <= 2'h0;
      auto_ff <= 1'b0;
      pins_ff <= '{cs_n: 1'b1, we_n: 1'b1, load_n: 1'b1, addr: 2'h0, data: 8'h00};
      done_ff <= 1'b0;
      req_ready_ff <= 1'b0;
      settling_speed_select_ff <= 1'b0;
      power_down_pin_ff <= 1'b0;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      last_ff <= nxt_last;
      auto_ff <= nxt_auto;
      pins_ff <= nxt_pins;
      done_ff <= nxt_done;
      req_ready_ff <= nxt_ready;
      settling_speed_select_ff <= nxt_spd;
      power_down_pin_ff <= nxt_pwr;
    end
  end

endmodule // dpw_host

// >>> test/dpw_host_props.sv
`timescale 1ns/1ps
module dpw_host_props
  import dpw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic fast_settle,
  input wire logic done_ff,
  input wire dpw_pins_t pins_ff,
  input wire logic settling_speed_select_ff
);
  default clocking @(posedge core_clk); endclocking
  // A low clock enable stretches every pulse, so the width checks rest while it is low.
  default disable iff (rst || !ce);
  we_in_cs_a: assert property (!pins_ff.we_n |-> !pins_ff.cs_n)
    else $error("strobe outside select");
  addr_ok_a: assert property (!pins_ff.cs_n |-> pins_ff.addr != 2'h2)
    else $error("bad address");
  upper_pad_a: assert property (!pins_ff.cs_n && pins_ff.addr == DPW_ADDR_UPPER
    |-> pins_ff.data[7:4] == DPW_UPPER_PAD) else $error("upper pad");
  strobe_len_a: assert property ($fell(pins_ff.we_n) |=> !pins_ff.we_n ##1 pins_ff.we_n)
    else $error("strobe width");
  load_gap_a: assert property ($fell(pins_ff.load_n)
    |-> $past(pins_ff.we_n) && pins_ff.we_n && pins_ff.cs_n) else $error("load gap");
  load_len_a: assert property ($fell(pins_ff.load_n) |=> !pins_ff.load_n ##1 pins_ff.load_n)
    else $error("load width");
  load_done_a: assert property ($rose(pins_ff.load_n) |-> done_ff)
    else $error("done missing");
  speed_copy_a: assert property (ce |=> settling_speed_select_ff == $past(fast_settle))
    else $error("speed copy");
  freeze_hold_a: assert property (disable iff (rst) !ce
    |=> $stable(pins_ff) && $stable(done_ff)) else $error("freeze moved");
  reset_idle_a: assert property (disable iff (1'b0) rst
    |=> pins_ff.cs_n && pins_ff.we_n && pins_ff.load_n && !done_ff)
    else $error("reset not idle");
endmodule // dpw_host_props
bind dpw_host dpw_host_props props_u (.core_clk(core_clk), .rst(rst), .ce(ce),
  .fast_settle(fast_settle), .done_ff(done_ff), .pins_ff(pins_ff),
  .settling_speed_select_ff(settling_speed_select_ff));

// >>> test/dpw_dev_model.sv
`timescale 1ns/1ps
module dpw_dev_model
  import dpw_pkg::*;
(
  input wire logic por,
  input wire dpw_pins_t pins,
  output logic [7:0] lo_ff,
  output logic [3:0] hi_ff,
  output logic [7:0] ctrl_ff,
  output logic [11:0] code_ff
);
  wire logic we_n = pins.we_n;
  always @(posedge we_n or posedge por)
  begin
    if (por)
    begin
      lo_ff <= 8'h00;
      hi_ff <= 4'h0;
      ctrl_ff <= 8'h00;
    end
    else if (!pins.cs_n)
    begin
      case (pins.addr)
        DPW_ADDR_LOWER: lo_ff <= pins.data;
        DPW_ADDR_UPPER: hi_ff <= pins.data[3:0];
        DPW_ADDR_CTRL: ctrl_ff <= pins.data;
        default: ;
      endcase
    end
  end
  // Level sensitive on purpose: a load held low lets every write through.
  always @*
  begin
    if (por)
      code_ff = 12'h000;
    else if (!pins.load_n)
      code_ff = {hi_ff, lo_ff};
  end
endmodule // dpw_dev_model

// >>> test/dpw_host_bench.sv
`timescale 1ns/1ps
module dpw_host_bench
  import dpw_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  logic en = 1'b0;
  logic al = 1'b0;
  logic fs = 1'b0;
  logic pd = 1'b0;
  logic [11:0] rc = 12'h000;
  logic [7:0] cr = 8'h00;
  logic rdy, done, settling_speed_select, pdo;
  dpw_pins_t pins;
  logic [7:0] lo, ctrl;
  logic [3:0] hi;
  logic [11:0] code;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  always #4 core_clk = ~core_clk;
  dpw_host dut_u (.core_clk(core_clk), .rst(rst), .ce(ce), .req_valid(req_valid),
    .req_code(rc), .req_ctrl_en(en), .req_ctrl(cr), .req_auto_load(al),
    .fast_settle(fs), .power_down(pd), .req_ready_ff(rdy), .done_ff(done),
    .pins_ff(pins), .settling_speed_select_ff(settling_speed_select), .power_down_pin_ff(pdo));
  dpw_dev_model dev_u (.por(rst), .pins(pins), .lo_ff(lo), .hi_ff(hi),
    .ctrl_ff(ctrl), .code_ff(code));
  task complete_run;
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic start(input logic [11:0] c, input logic ce_w, input logic [7:0] cv,
    input logic ld);
    rc = c;
    en = ce_w;
    cr = cv;
    al = ld;
    repeat (50) if (rdy !== 1'b1) @(negedge core_clk);
    req_valid = 1'b1;
    repeat (ce_w ? 3 : 2) @(negedge core_clk);
    req_valid = 1'b0;
  endtask
  task automatic send(input logic [11:0] c, input logic ce_w, input logic [7:0] cv,
    input logic ld);
    start(c, ce_w, cv, ld);
    repeat (100) if (done !== 1'b1) @(negedge core_clk);
    chk("done", 12'h001, {11'h0, done});
    @(negedge core_clk);
    chk("done pulse", 12'h000, {11'h0, done});
  endtask
  task t_por;
    chk("por", 12'h000, {hi, lo});
    chk("por code", 12'h000, code);
    chk("ready", 12'h001, {11'h0, rdy});
  endtask
  task t_full;
    send(12'hFFF, 1'b1, DPW_CTRL_DEFAULT, 1'b1);
    chk("code", 12'hFFF, code);
    chk("ctrl", {4'h0, DPW_CTRL_DEFAULT}, {4'h0, ctrl});
    chk("hi", 12'h00F, {8'h00, hi});
  endtask
  task t_hold;
    send(12'h3A5, 1'b0, 8'h00, 1'b0);
    chk("held", 12'hFFF, code);
    chk("lo", 12'h0A5, {4'h0, lo});
    chk("ctrl", {4'h0, DPW_CTRL_DEFAULT}, {4'h0, ctrl});
    send(12'h000, 1'b1, 8'h06, 1'b1);
    chk("zero", 12'h000, code);
    chk("ctrl", 12'h006, {4'h0, ctrl});
  endtask
  task t_pins;
    for (int i = 0; i < 4; i++)
    begin
      fs = i[0];
      pd = i[1];
      @(negedge core_clk);
      chk("speed", {11'h0, fs}, {11'h0, settling_speed_select});
      chk("pdown", {11'h0, pd}, {11'h0, pdo});
    end
  endtask
  // Freezing in mid-strobe must hold the pins and still end with the full code.
  task t_freeze;
    start(12'h5C3, 1'b0, 8'h00, 1'b1);
    repeat (20) if (pins.we_n !== 1'b0) @(negedge core_clk);
    ce = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("frozen pins", 12'h1C3, {1'b0, pins.cs_n, pins.we_n, pins.load_n, pins.data});
    chk("frozen done", 12'h000, {11'h0, done});
    ce = 1'b1;
    repeat (100) if (done !== 1'b1) @(negedge core_clk);
    chk("thawed code", 12'h5C3, code);
    @(negedge core_clk);
  endtask
  task t_reset;
    start(12'h2B7, 1'b1, DPW_CTRL_DEFAULT, 1'b1);
    repeat (20) if (pins.cs_n !== 1'b0) @(negedge core_clk);
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    chk("rst pins", 12'h007, {9'h0, pins.cs_n, pins.we_n, pins.load_n});
    chk("rst latch", 12'h000, {hi, lo});
    chk("rst code", 12'h000, code);
    chk("rst ctrl", 12'h000, {4'h0, ctrl});
    @(negedge core_clk);
    chk("rst ready", 12'h001, {11'h0, rdy});
  endtask
  // A late edge on reset gives the edge-triggered byte latches of the model a clear at power-on.
  initial
  begin
    rst = 1'b0;
    #1;
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_por;
    t_full;
    t_hold;
    t_freeze;
    t_reset;
    t_pins;
    complete_run;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      complete_run;
    end
  end
endmodule // dpw_host_bench
